// [shared/gantry_pkg.sv]
package gantry_pkg;
    // axi4-lite register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;  // start, pause, stop, halt requests
    localparam logic [7:0] ADDR_PARAM    = 8'h04;  // file, axis set, depth
    localparam logic [7:0] ADDR_SCALE    = 8'h08;  // override percent
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;  // busy, active and outcome flags
    localparam logic [7:0] ADDR_FAULT    = 8'h10;  // fault code
    localparam logic [7:0] ADDR_ROW      = 8'h14;  // executing row number
    localparam logic [7:0] ADDR_SPEED    = 8'h18;  // current tool speed
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;  // sticky events, read only
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;  // write one to clear
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;  // interrupt enable
    localparam logic [7:0] ADDR_PROG     = 8'h28;  // program length and feed rate
    localparam logic [7:0] ADDR_ACCEL    = 8'h2c;  // acc [15:0], dec [31:16]

    // ctrl bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_PAUSE = 1;
    localparam int CTRL_STOP  = 2;
    localparam int CTRL_HALT  = 3;

    // status bit positions
    localparam int ST_BUSY   = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_DONE   = 2;
    localparam int ST_ABORT  = 3;
    localparam int ST_ERROR  = 4;

    // legal parameter ranges
    localparam logic [15:0] FILE_MIN  = 16'h0001;
    localparam logic [15:0] FILE_MAX  = 16'h0040;
    localparam logic [7:0]  AXIS_MIN  = 8'h01;
    localparam logic [7:0]  AXIS_MAX  = 8'h08;
    localparam logic [15:0] DEPTH_REQ = 16'h0001;
    localparam logic [15:0] MODE_REQ  = 16'h0000;
    localparam logic [9:0]  SCALE_MAX = 10'h1f4;  // 500 percent
    localparam logic [9:0]  SCALE_ONE = 10'h064;  // 100 percent

    // fault codes
    localparam logic [15:0] FAULT_NONE  = 16'h0000;
    localparam logic [15:0] FAULT_FILE  = 16'h0001;
    localparam logic [15:0] FAULT_AXIS  = 16'h0002;
    localparam logic [15:0] FAULT_SCALE = 16'h0003;
    localparam logic [15:0] FAULT_RSVD  = 16'h0004;
    localparam logic [15:0] FAULT_MOVE  = 16'h0005;

    // interrupt event bits
    localparam int EV_DONE  = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_ERROR = 2;

    // reset values, then the fixed tick count per row
    localparam logic [15:0] RST_ROWS  = 16'h0004;
    localparam logic [15:0] RST_FEED  = 16'h0100;
    localparam logic [15:0] RST_ACC   = 16'h0010;
    localparam logic [15:0] SEG_TICKS = 16'h0020;  // tick count per row, ticks counted at any nonzero speed

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN, ST_END} phase_e;
endpackage

// [verilog/gantry_interpolation_block.sv]
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module gantry_interpolation_block (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  axis_standstill,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             busy,
    output logic             active,
    output logic             done,
    output logic             preempted_flag,
    output logic             error,
    output logic [15:0]      fault_code,
    output logic [31:0]      executing_row_number,
    output logic [31:0]      tool_speed,
    output logic             irq
);
    typedef struct packed {
        logic                   awready, wready, bvalid, arready, rvalid;
        logic [7:0]             awaddr;
        logic                   aw_have;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   w_have;
        logic [1:0]             bresp, rresp;
        logic [31:0]            rdata;
        logic [31:0]            ctrl, param, prog, accel;
        logic [9:0]             scale_in;
        logic                   start_q, stop_q, halt_q;
        gantry_pkg::phase_e     phase;
        logic                   busy, active, done, abort, error;
        logic                   pulse_clr;      // outcome flags clear the cycle after this is set
        logic [15:0]            fault;
        logic [9:0]             scale;
        logic [15:0]            file_no;
        logic [7:0]             axis_set;
        logic [31:0]            row;
        logic [15:0]            tick;
        logic [31:0]            speed;
        logic [2:0]             ev, ev_en;
        logic                   irq;
    } state_s;

    state_s s_r, s_nxt;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // move value toward target by at most step
    function automatic logic [31:0] ramp(input logic [31:0] cur, input logic [31:0] tgt,
                                         input logic [15:0] up, input logic [15:0] dn);
        logic [31:0] r;
        r = tgt;
        if (cur < tgt && tgt - cur > {16'h0000, up}) begin
            r = cur + {16'h0000, up};
        end else if (cur > tgt && cur - tgt > {16'h0000, dn}) begin
            r = cur - {16'h0000, dn};
        end
        return r;
    endfunction

    logic        wr_go;
    logic        start_rise, start_fall, stop_rise, halt_rise, start_lvl;
    logic [31:0] target;
    logic [15:0] acc, dec;
    logic [2:0]  ev_set;
    logic [31:0] rd_val;
    logic        rd_ok;

    // read mux, unmapped addresses answer slverr
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            gantry_pkg::ADDR_CTRL:     rd_val = s_r.ctrl;
            gantry_pkg::ADDR_PARAM:    rd_val = s_r.param;
            gantry_pkg::ADDR_SCALE:    rd_val = {22'h000000, s_r.scale_in};
            gantry_pkg::ADDR_STATUS:   rd_val = {27'h0000000, s_r.error, s_r.abort, s_r.done,
                                                 s_r.active, s_r.busy};
            gantry_pkg::ADDR_FAULT:    rd_val = {16'h0000, s_r.fault};
            gantry_pkg::ADDR_ROW:      rd_val = s_r.row;
            gantry_pkg::ADDR_SPEED:    rd_val = s_r.speed;
            gantry_pkg::ADDR_IRQ_STAT: rd_val = {29'h00000000, s_r.ev};
            gantry_pkg::ADDR_IRQ_CLR:  rd_val = 32'h0000_0000;
            gantry_pkg::ADDR_IRQ_EN:   rd_val = {29'h00000000, s_r.ev_en};
            gantry_pkg::ADDR_PROG:     rd_val = s_r.prog;
            gantry_pkg::ADDR_ACCEL:    rd_val = s_r.accel;
            default:                   rd_ok = 1'b0;
        endcase
    end

    // control bits are sampled once per cycle, edges taken against the last sample
    assign start_lvl  = s_r.ctrl[gantry_pkg::CTRL_START];
    assign start_rise = start_lvl & ~s_r.start_q;
    assign start_fall = ~start_lvl & s_r.start_q;
    assign stop_rise  = s_r.ctrl[gantry_pkg::CTRL_STOP] & ~s_r.stop_q;
    assign halt_rise  = s_r.ctrl[gantry_pkg::CTRL_HALT] & ~s_r.halt_q;
    assign acc        = s_r.accel[15:0];
    assign dec        = s_r.accel[31:16];
    assign wr_go      = s_r.aw_have & s_r.w_have & ~s_r.bvalid;

    // speed target; operands widened first, a 16-bit product would wrap above 255 percent
    assign target = s_r.ctrl[gantry_pkg::CTRL_PAUSE] ? 32'h0000_0000 :
                    32'(s_r.prog[31:16]) * 32'(s_r.scale)
                    / 32'(gantry_pkg::SCALE_ONE);

    always_comb begin
        s_nxt  = s_r;
        ev_set = 3'b000;
        // axi write path: address and data accepted in either order
        s_nxt.awready = ~s_r.aw_have & ~s_r.awready;
        s_nxt.wready  = ~s_r.w_have & ~s_r.wready;
        if (s_axi_awvalid & s_r.awready) begin
            s_nxt.awaddr  = s_axi_awaddr;
            s_nxt.aw_have = 1'b1;
            s_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid & s_r.wready) begin
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
            s_nxt.w_have = 1'b1;
            s_nxt.wready = 1'b0;
        end
        if (s_r.bvalid & s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // read path: one-cycle arready pulse, data the next cycle
        s_nxt.arready = ~s_r.arready & ~s_r.rvalid & s_axi_arvalid;
        if (s_axi_arvalid & s_r.arready) begin
            s_nxt.rdata  = rd_val;
            s_nxt.rresp  = rd_ok ? gantry_pkg::RESP_OKAY : gantry_pkg::RESP_SLVERR;
            s_nxt.rvalid = 1'b1;
        end
        if (s_r.rvalid & s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // edge history
        s_nxt.start_q = start_lvl;
        s_nxt.stop_q  = s_r.ctrl[gantry_pkg::CTRL_STOP];
        s_nxt.halt_q  = s_r.ctrl[gantry_pkg::CTRL_HALT];

        // outcome flags: pulse variants drop after one cycle, or two when the clear is armed in end, others on start low
        if (s_r.pulse_clr | start_fall) begin
            s_nxt.done      = 1'b0;
            s_nxt.abort     = 1'b0;
            s_nxt.error     = 1'b0;
            s_nxt.pulse_clr = 1'b0;
        end

        case (s_r.phase)
            gantry_pkg::ST_IDLE: begin
                if (start_rise) begin
                    // file, axis set and scale latched here only; later changes to these are ignored, prog and accel are read live
                    s_nxt.scale    = s_r.scale_in;
                    s_nxt.file_no  = s_r.param[15:0];
                    s_nxt.axis_set = s_r.param[23:16];
                    s_nxt.done     = 1'b0;
                    s_nxt.abort    = 1'b0;
                    s_nxt.error    = 1'b0;
                    s_nxt.fault    = gantry_pkg::FAULT_NONE;
                    s_nxt.row      = 32'h0000_0000;
                    s_nxt.tick     = 16'h0000;
                    if (s_r.param[15:0] < gantry_pkg::FILE_MIN ||
                        s_r.param[15:0] > gantry_pkg::FILE_MAX) begin
                        s_nxt.fault = gantry_pkg::FAULT_FILE;
                    end else if (s_r.param[23:16] < gantry_pkg::AXIS_MIN ||
                                 s_r.param[23:16] > gantry_pkg::AXIS_MAX) begin
                        s_nxt.fault = gantry_pkg::FAULT_AXIS;
                    end else if (s_r.scale_in > gantry_pkg::SCALE_MAX) begin
                        s_nxt.fault = gantry_pkg::FAULT_SCALE;
                    end else if ({8'h00, s_r.param[31:24]} != gantry_pkg::DEPTH_REQ) begin
                        s_nxt.fault = gantry_pkg::FAULT_RSVD;
                    end else if (s_r.param[31:24] == 8'h00 && 1'b0) begin
                        s_nxt.fault = gantry_pkg::FAULT_RSVD;
                    end else if (axis_standstill != 8'hff) begin
                        s_nxt.fault = gantry_pkg::FAULT_MOVE;
                    end
                    s_nxt.busy  = 1'b1;
                    s_nxt.phase = gantry_pkg::ST_ARM;
                end
            end
            gantry_pkg::ST_ARM: begin
                if (s_r.fault != gantry_pkg::FAULT_NONE) begin
                    s_nxt.error = 1'b1;
                    s_nxt.busy  = 1'b0;
                    s_nxt.phase = gantry_pkg::ST_END;
                    ev_set[gantry_pkg::EV_ERROR] = 1'b1;
                end else begin
                    s_nxt.active = 1'b1;
                    s_nxt.phase  = gantry_pkg::ST_RUN;
                end
            end
            gantry_pkg::ST_RUN: begin
                s_nxt.speed = ramp(s_r.speed, target, acc, dec);
                if (s_r.speed != 32'h0000_0000) begin
                    s_nxt.tick = 16'(s_r.tick + 16'h0001);
                end
                if (s_r.tick >= gantry_pkg::SEG_TICKS) begin
                    s_nxt.tick = 16'h0000;
                    s_nxt.row  = s_r.row + 32'h0000_0001;
                end
                // one outcome only, preemption ahead of stop ahead of end
                if (halt_rise) begin
                    s_nxt.abort = 1'b1;
                    ev_set[gantry_pkg::EV_ABORT] = 1'b1;
                end else if (stop_rise ||
                             s_r.row + 32'h0000_0001 >= {16'h0000, s_r.prog[15:0]} &&
                             s_r.tick >= gantry_pkg::SEG_TICKS) begin
                    s_nxt.done  = 1'b1;
                    s_nxt.speed = 32'h0000_0000;
                    s_nxt.row   = s_r.row;                             // last row stays shown
                    ev_set[gantry_pkg::EV_DONE] = 1'b1;
                end
                if (halt_rise | stop_rise | ev_set[gantry_pkg::EV_DONE]) begin
                    s_nxt.busy   = 1'b0;
                    s_nxt.active = 1'b0;
                    s_nxt.speed  = 32'h0000_0000;
                    s_nxt.phase  = gantry_pkg::ST_END;
                    // start already low: arm the clear now so the flag lasts one cycle
                    if (!start_lvl) begin
                        s_nxt.pulse_clr = 1'b1;
                    end
                end
            end
            gantry_pkg::ST_END: begin
                // start already low: arm the clear, so the flag drops after two cycles
                if (!start_lvl) begin
                    s_nxt.pulse_clr = 1'b1;
                end
                if (!start_lvl || start_fall) begin
                    s_nxt.phase = gantry_pkg::ST_IDLE;
                end
            end
            default: s_nxt.phase = gantry_pkg::ST_IDLE;
        endcase
        if (s_r.phase == gantry_pkg::ST_END && s_r.pulse_clr) begin
            s_nxt.pulse_clr = 1'b0;
        end

        // register writes, committed with the response
        if (wr_go) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = gantry_pkg::RESP_OKAY;
            case (s_r.awaddr)
                gantry_pkg::ADDR_CTRL:   s_nxt.ctrl = merge(s_r.ctrl, s_r.wdata, s_r.wstrb);
                gantry_pkg::ADDR_PARAM:  s_nxt.param = merge(s_r.param, s_r.wdata, s_r.wstrb);
                gantry_pkg::ADDR_SCALE:  s_nxt.scale_in = s_r.wdata[9:0];
                gantry_pkg::ADDR_IRQ_CLR: s_nxt.ev = s_r.ev & ~s_r.wdata[2:0];
                gantry_pkg::ADDR_IRQ_EN: s_nxt.ev_en = s_r.wdata[2:0];
                gantry_pkg::ADDR_PROG:   s_nxt.prog = merge(s_r.prog, s_r.wdata, s_r.wstrb);
                gantry_pkg::ADDR_ACCEL:  s_nxt.accel = merge(s_r.accel, s_r.wdata, s_r.wstrb);
                gantry_pkg::ADDR_STATUS, gantry_pkg::ADDR_FAULT, gantry_pkg::ADDR_ROW,
                gantry_pkg::ADDR_SPEED, gantry_pkg::ADDR_IRQ_STAT: ;
                default: s_nxt.bresp = gantry_pkg::RESP_SLVERR;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s_nxt.ev  = s_nxt.ev | ev_set;
        s_nxt.irq = |(s_nxt.ev & s_nxt.ev_en);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r       <= '0;
            s_r.phase <= gantry_pkg::ST_IDLE;
            s_r.param <= {gantry_pkg::DEPTH_REQ[7:0], 24'h000000};
            s_r.scale_in <= gantry_pkg::SCALE_ONE;
            s_r.prog  <= {gantry_pkg::RST_FEED, gantry_pkg::RST_ROWS};
            s_r.accel <= {gantry_pkg::RST_ACC, gantry_pkg::RST_ACC};
        end else begin
            s_r <= s_nxt;
        end
    end

    // all outputs straight from the state register
    assign s_axi_awready        = s_r.awready;
    assign s_axi_wready         = s_r.wready;
    assign s_axi_bvalid         = s_r.bvalid;
    assign s_axi_bresp          = s_r.bresp;
    assign s_axi_arready        = s_r.arready;
    assign s_axi_rvalid         = s_r.rvalid;
    assign s_axi_rdata          = s_r.rdata;
    assign s_axi_rresp          = s_r.rresp;
    assign busy                 = s_r.busy;
    assign active               = s_r.active;
    assign done                 = s_r.done;
    assign preempted_flag       = s_r.abort;
    assign error                = s_r.error;
    assign fault_code           = s_r.fault;
    assign executing_row_number = s_r.row;
    assign tool_speed           = s_r.speed;
    assign irq                  = s_r.irq;
endmodule // gantry_interpolation_block

// [verif/axis_group_model.sv]
`timescale 1ns/1ps
// axis group beside the block: reports standstill per axis from the commanded tool speed
module axis_group_model (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [31:0] tool_speed,
    input  wire logic        hold_moving,
    output logic [7:0]       axis_standstill
);
    // hold_moving leaves two axes coasting, which a start must refuse
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) axis_standstill <= 8'hff;
        else axis_standstill <= (tool_speed == 32'h0 && !hold_moving) ? 8'hff : 8'h7e;
    end
endmodule // axis_group_model

// [verif/gantry_chk.sv]
`timescale 1ns/1ps
module gantry_chk (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        busy,
    input wire logic        active,
    input wire logic        done,
    input wire logic        preempted_flag,
    input wire logic        error,
    input wire logic [15:0] fault_code,
    input wire logic [31:0] executing_row_number
);
    // one clock domain, so clocking and reset are declared once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire [2:0] outc = {done, preempted_flag, error};

    AST_BUSY_THEN_ACTIVE: assert property (
        $rose(busy) |-> !active ##1 (active || error))
        else $error("active did not follow busy by one cycle");
    AST_DONE_DROPS: assert property ($rose(done) |-> !busy && !active)
        else $error("busy or active left high at completion");
    AST_ABORT_DROPS: assert property ($rose(preempted_flag) |-> !busy && !active)
        else $error("busy or active left high at preemption");
    AST_ERROR_CODE: assert property ($rose(error) |-> !busy && !active
        && fault_code != gantry_pkg::FAULT_NONE) else $error("error without code or with busy");
    AST_ACTIVE_IN_BUSY: assert property (active |-> busy)
        else $error("active outside busy");
    AST_ONE_OUTCOME: assert property ($onehot0(outc))
        else $error("more than one outcome flag");
    AST_BUSY_NO_OUTCOME: assert property (busy |-> outc == 3'b000)
        else $error("outcome flag during busy");
    AST_OUTCOME_AFTER_RUN: assert property (
        (outc & ~$past(outc)) != 3'b000 |-> $past(busy))
        else $error("outcome raised without a run");
    AST_ROW_STEP: assert property (
        active && $past(active) && $changed(executing_row_number)
        |-> executing_row_number == $past(executing_row_number) + 32'h1)
        else $error("row number skipped");
    cover property ($rose(done));
    cover property ($rose(preempted_flag));
    cover property ($rose(error));
endmodule // gantry_chk

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        hold_moving = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, axis_standstill;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, executing_row_number, tool_speed;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        busy, active, done, preempted_flag, error;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] fault_code;
    int          fails = 0, checks_done = 0;
    wire [4:0]   st = {error, preempted_flag, done, active, busy};

    always #2.5 mclk = ~mclk;

    gantry_interpolation_block gantry_interpolation_block_i (.mclk, .nrst, .axis_standstill,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .busy, .active, .done, .preempted_flag, .error,
        .fault_code, .executing_row_number, .tool_speed, .irq);
    axis_group_model axis_group_model_i (.mclk, .nrst, .tool_speed, .hold_moving,
        .axis_standstill);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // handshakes are looked at mid-cycle, released just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta, tw, fin;
        fin = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(negedge mclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            fin = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ta, fin;
        fin = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!fin) begin
            @(negedge mclk);
            ta = s_axi_arvalid & s_axi_arready;
            fin = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    // bounded wait on one status flag, ends mid-cycle
    task automatic wst(input int i, input logic v);
        int n;
        n = 0;
        @(negedge mclk);
        while (st[i] !== v && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk(st[i], v);
    endtask
    task automatic go(input logic [31:0] c);
        wr(gantry_pkg::ADDR_CTRL, c, rsp);
        wst(gantry_pkg::ST_BUSY, 1'b1);
    endtask
    task automatic t_run();
        wr(gantry_pkg::ADDR_SCALE, 32'd200, rsp);
        go(32'h1);
        chk(active, 1'b0);
        @(negedge mclk);
        chk(active, 1'b1);
        wr(gantry_pkg::ADDR_SCALE, 32'd300, rsp);
        repeat (60) @(negedge mclk);
        chk(tool_speed, 32'(gantry_pkg::RST_FEED) * 32'd2);
        wst(gantry_pkg::ST_DONE, 1'b1);
        chk({busy, active}, 2'b00);
        chk(executing_row_number, 32'(gantry_pkg::RST_ROWS) - 32'h1);
        repeat (4) @(negedge mclk);
        chk(done, 1'b1);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        repeat (4) @(negedge mclk);
        chk(done, 1'b0);
        wr(gantry_pkg::ADDR_SCALE, 32'd200, rsp);
        $display("t_run ended");
    endtask
    task automatic t_drop();
        go(32'h1);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        wst(gantry_pkg::ST_DONE, 1'b1);
        @(negedge mclk);
        chk(done, 1'b0);
        $display("t_drop ended");
    endtask
    task automatic t_pause();
        go(32'h1);
        repeat (20) @(negedge mclk);
        wr(gantry_pkg::ADDR_CTRL, 32'h3, rsp);
        repeat (40) @(negedge mclk);
        chk(busy, 1'b1);
        chk(tool_speed, 32'h0);
        wr(gantry_pkg::ADDR_CTRL, 32'h1, rsp);
        repeat (50) @(negedge mclk);
        chk(tool_speed, 32'(gantry_pkg::RST_FEED) * 32'd2);
        wst(gantry_pkg::ST_DONE, 1'b1);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        $display("t_pause ended");
    endtask
    task automatic t_stop();
        go(32'h1);
        wst(gantry_pkg::ST_ACTIVE, 1'b1);
        wr(gantry_pkg::ADDR_CTRL, 32'h5, rsp);
        wst(gantry_pkg::ST_DONE, 1'b1);
        repeat (2) @(negedge mclk);
        chk({busy, active, preempted_flag}, 3'b000);
        chk(tool_speed, 32'h0);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        $display("t_stop ended");
    endtask
    task automatic t_halt();
        go(32'h1);
        wst(gantry_pkg::ST_ACTIVE, 1'b1);
        wr(gantry_pkg::ADDR_CTRL, 32'h9, rsp);
        wst(gantry_pkg::ST_ABORT, 1'b1);
        repeat (4) @(negedge mclk);
        chk({busy, active, preempted_flag}, 3'b001);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        repeat (4) @(negedge mclk);
        chk(preempted_flag, 1'b0);
        go(32'h1);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        wr(gantry_pkg::ADDR_CTRL, 32'h8, rsp);
        wst(gantry_pkg::ST_ABORT, 1'b1);
        @(negedge mclk);
        chk(preempted_flag, 1'b0);
        wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
        $display("t_halt ended");
    endtask
    // bad file, bad axis set, bad depth, bad scale, moving axes
    task automatic t_err();
        logic [31:0] prm [7] = '{32'h01010000, 32'h01010041, 32'h01000001, 32'h01090001,
                                 32'h02010001, 32'h01010001, 32'h01010001};
        logic [15:0] cd [7] = '{16'h1, 16'h1, 16'h2, 16'h2, 16'h4, 16'h3, 16'h5};
        for (int i = 0; i < 7; i++) begin
            wr(gantry_pkg::ADDR_PARAM, prm[i], rsp);
            wr(gantry_pkg::ADDR_SCALE, (i == 5) ? 32'h1f5 : 32'd200, rsp);
            hold_moving <= (i == 6);
            go(32'h1);
            wst(gantry_pkg::ST_ERROR, 1'b1);
            chk({busy, active, fault_code}, {2'b00, cd[i]});
            wr(gantry_pkg::ADDR_CTRL, 32'h0, rsp);
            hold_moving <= 1'b0;
            repeat (4) @(negedge mclk);
            chk(error, 1'b0);
        end
        wr(gantry_pkg::ADDR_SCALE, 32'd200, rsp);
        $display("t_err ended");
    endtask
    // error event is still sticky from the last run
    task automatic t_irq();
        logic [31:0] d;
        rd(gantry_pkg::ADDR_IRQ_STAT, d, rsp);
        chk(d & 32'h4, 32'h4);
        wr(gantry_pkg::ADDR_IRQ_EN, 32'h4, rsp);
        repeat (3) @(negedge mclk);
        chk(irq, 1'b1);
        wr(gantry_pkg::ADDR_IRQ_EN, 32'h0, rsp);
        repeat (3) @(negedge mclk);
        chk(irq, 1'b0);
        wr(gantry_pkg::ADDR_IRQ_EN, 32'h4, rsp);
        wr(gantry_pkg::ADDR_IRQ_CLR, 32'h4, rsp);
        repeat (3) @(negedge mclk);
        chk(irq, 1'b0);
        rd(8'h40, d, rsp);
        chk(rsp, gantry_pkg::RESP_SLVERR);
        $display("t_irq ended");
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        wr(gantry_pkg::ADDR_PARAM, 32'h01010001, rsp);
        t_run();
        t_drop();
        t_pause();
        t_stop();
        t_halt();
        t_err();
        t_irq();
        summarize();
    end
    // a hang costs one mismatch and ends the run
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        summarize();
    end
endmodule // tb_top

bind gantry_interpolation_block gantry_chk gantry_chk_i (.mclk, .nrst, .busy, .active, .done,
    .preempted_flag, .error, .fault_code, .executing_row_number);
